// ---- rtl/flsr_cfg.svh ----
// constants of the fuse, lock and signature reader: offsets, fields, counts
// assumes a 100 MHz core clock and a byte-addressed avalon register slave
`ifndef FLSR_CFG_SVH
`define FLSR_CFG_SVH

`define FLSR_CTRL_INDEX      8'h37
`define FLSR_STAT_INDEX      8'h38
`define FLSR_CTRL_ADDR       8'hdc
`define FLSR_STAT_ADDR       8'he0

`define FLSR_BIT_ENABLE      0
`define FLSR_BIT_ERASE       1
`define FLSR_BIT_WRITE       2
`define FLSR_BIT_LOCK        3
`define FLSR_BIT_RWW_EN      4
`define FLSR_BIT_SIG         5
`define FLSR_BIT_BUSY        6
`define FLSR_BIT_INT_EN      7

`define FLSR_PTR_FUSE_LOW    2'h0
`define FLSR_PTR_LOCK        2'h1
`define FLSR_PTR_FUSE_EXT    2'h2
`define FLSR_PTR_FUSE_HIGH   2'h3
`define FLSR_SIG_ID1         3'h0
`define FLSR_SIG_CAL         3'h1
`define FLSR_SIG_ID2         3'h2
`define FLSR_SIG_GAIN        3'h3
`define FLSR_SIG_ID3         3'h4
`define FLSR_RESERVED_BYTE   8'hff
`define FLSR_LOCK_PAD        2'h3

`define FLSR_BLOCK_START     15'h3800
`define FLSR_LOAD_OPEN       3'h1
`define FLSR_STORE_WINDOW    3'h4
`define FLSR_SIG_LAST        3'h2
`define FLSR_WIN_LAST        3'h1

`define FLSR_CLK_PERIOD_NS   10
`define FLSR_PROG_MIN_NS     3700000
`define FLSR_PROG_MAX_NS     4500000
`define FLSR_PROG_CYCLES     ((`FLSR_PROG_MIN_NS + `FLSR_CLK_PERIOD_NS - 1) / `FLSR_CLK_PERIOD_NS)
`define FLSR_PROG_W          19

`endif

// ---- rtl/flsr_countdown.sv ----
// loadable down counter, stops at zero
// assumes a synchronous active-low clear
`default_nettype none
module flsr_countdown #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic      [W-1:0] count,
  output logic              last
);

  typedef struct packed {
    logic [W-1:0] count;
  } flsr_cnt_t;

  flsr_cnt_t s;
  flsr_cnt_t next_s;

  always_comb begin
    next_s = s;
    if (!rst_n) begin
      next_s.count = '0;
    end else if (load) begin
      next_s.count = load_value;
    end else if (s.count != '0) begin
      next_s.count = s.count - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign count = s.count;
  assign last  = (s.count == W'(1));

endmodule : flsr_countdown
`default_nettype wire

// ---- rtl/flsr_info_mux.sv ----
// selects the fuse, lock or signature byte that a special load returns
// assumes programmed-bit inputs are 1 when the fuse or lock is programmed
`include "flsr_cfg.svh"
`default_nettype none
module flsr_info_mux #(
  parameter logic [7:0] ID1 = 8'h5a,  // arbitrary value
  parameter logic [7:0] ID2 = 8'ha5,  // arbitrary value
  parameter logic [7:0] ID3 = 8'h3c   // arbitrary value
) (
  input  wire logic       sig_mode,
  input  wire logic [2:0] ptr,
  input  wire logic [7:0] fuse_low_prog,
  input  wire logic [7:0] fuse_high_prog,
  input  wire logic [7:0] fuse_ext_prog,
  input  wire logic [5:0] lock_prog,
  input  wire logic [7:0] osc_cal,
  input  wire logic [7:0] temp_sensor_offset,
  input  wire logic [7:0] temp_sensor_gain,
  output logic      [7:0] info_byte
);

  logic [7:0] fuse_byte;
  logic [7:0] sig_byte;

  always_comb begin
    case (ptr[1:0])
      `FLSR_PTR_FUSE_LOW:  fuse_byte = ~fuse_low_prog;
      `FLSR_PTR_LOCK:      fuse_byte = {`FLSR_LOCK_PAD, ~lock_prog};
      `FLSR_PTR_FUSE_EXT:  fuse_byte = ~fuse_ext_prog;
      `FLSR_PTR_FUSE_HIGH: fuse_byte = ~fuse_high_prog;
      default:             fuse_byte = `FLSR_RESERVED_BYTE;
    endcase
    case (ptr)
      `FLSR_SIG_ID1:  sig_byte = ID1;
      `FLSR_SIG_CAL:  sig_byte = osc_cal;
      `FLSR_SIG_ID2:  sig_byte = ID2;
      `FLSR_SIG_GAIN: sig_byte = temp_sensor_gain;
      `FLSR_SIG_ID3:  sig_byte = ID3;
      default:        sig_byte = `FLSR_RESERVED_BYTE;
    endcase
    if (sig_mode) begin
      info_byte = sig_byte;
    end else begin
      info_byte = fuse_byte;
    end
  end

  // offset byte shares a pointer value with id two; kept reachable for lint
  logic unused_offset;
  assign unused_offset = ^temp_sensor_offset;

endmodule : flsr_info_mux
`default_nettype wire

// ---- rtl/flsr_pkg.sv ----
// types of the fuse, lock and signature reader
// assumes flsr_cfg.svh is compiled alongside
`default_nettype none
package flsr_pkg;

  typedef enum logic [4:0] {
    mode_idle  = 5'h01,
    mode_info  = 5'h02,
    mode_sig   = 5'h04,
    mode_store = 5'h08,
    mode_prog  = 5'h10
  } flsr_mode_t;

  typedef enum logic [2:0] {
    op_none   = 3'h0,
    op_erase  = 3'h1,
    op_write  = 3'h2,
    op_lock   = 3'h3,
    op_load   = 3'h4,
    op_rww_en = 3'h5
  } flsr_op_t;

  typedef struct packed {
    flsr_mode_t  mode;
    logic [4:0]  cmd;
    logic        int_en;
    logic        conc_busy;
    logic        prog_blocking;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  load_data;
    logic        load_valid;
    logic        op_start;
    flsr_op_t    op_code;
    logic [15:0] op_addr;
    logic [15:0] op_data;
  } flsr_state_t;

endpackage : flsr_pkg
`default_nettype wire

// ---- rtl/flsr_reader.sv ----
// self-programming control: fuse, lock and signature reads, timed flash ops
// assumes cpu load/store strobes are one-cycle pulses and flash read data
// arrives combinationally in the cycle of the read request
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`include "flsr_cfg.svh"
`default_nettype none
module flsr_reader #(
  parameter int PROG_CYCLES = `FLSR_PROG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        load_req,
  input  wire logic        store_req,
  input  wire logic [15:0] z_ptr,
  input  wire logic [15:0] store_data,
  output logic      [7:0]  load_data,
  output logic             load_valid,
  output logic             flash_rd_req,
  output logic      [14:0] flash_rd_addr,
  input  wire logic [15:0] flash_rd_data,
  input  wire logic        eeprom_write_pending,
  input  wire logic [7:0]  fuse_low_prog,
  input  wire logic [7:0]  fuse_high_prog,
  input  wire logic [7:0]  fuse_ext_prog,
  input  wire logic [5:0]  lock_prog,
  input  wire logic [7:0]  osc_cal,
  input  wire logic [7:0]  temp_sensor_offset,
  input  wire logic [7:0]  temp_sensor_gain,
  output logic             flash_op_start,
  output flsr_pkg::flsr_op_t flash_op_code,
  output logic      [15:0] flash_op_addr,
  output logic      [15:0] flash_op_data,
  output logic             cpu_halt,
  output logic             concurrent_section_busy
);

  flsr_pkg::flsr_state_t s;
  flsr_pkg::flsr_state_t next_s;

  logic [2:0]              win_count;
  logic                    win_last;
  logic                    win_load;
  logic [`FLSR_PROG_W-1:0] prog_count;
  logic                    prog_last;
  logic                    prog_load;
  logic [7:0]              info_byte;

  logic       acc;
  logic       do_write;
  logic       ctrl_sel;
  logic       stat_sel;
  logic       self_prog_enable;
  logic       prog_active;
  logic       special_load;
  logic       store_ok;
  logic       conc_target;
  logic [7:0] self_prog_control_reg;
  logic [7:0] status_reg;
  logic [7:0] flash_byte;
  logic       cmd_erase;
  logic       cmd_write;
  logic       cmd_rww_en;

  localparam logic [`FLSR_PROG_W-1:0] PROG_LOAD = `FLSR_PROG_W'(PROG_CYCLES);

  flsr_countdown #(
    .W (3)
  ) u_window (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (win_load),
    .load_value (`FLSR_STORE_WINDOW),
    .count      (win_count),
    .last       (win_last)
  );

  // programming timer survives system reset; only power-on clears it
  flsr_countdown #(
    .W (`FLSR_PROG_W)
  ) u_prog_timer (
    .clk        (clk),
    .rst_n      (por_n),
    .load       (prog_load),
    .load_value (PROG_LOAD),
    .count      (prog_count),
    .last       (prog_last)
  );

  flsr_info_mux u_info (
    .sig_mode           (s.mode == flsr_pkg::mode_sig),
    .ptr                (z_ptr[2:0]),
    .fuse_low_prog      (fuse_low_prog),
    .fuse_high_prog     (fuse_high_prog),
    .fuse_ext_prog      (fuse_ext_prog),
    .lock_prog          (lock_prog),
    .osc_cal            (osc_cal),
    .temp_sensor_offset (temp_sensor_offset),
    .temp_sensor_gain   (temp_sensor_gain),
    .info_byte          (info_byte)
  );

  // register view
  assign prog_active      = (s.mode == flsr_pkg::mode_prog);
  assign self_prog_enable = (s.mode != flsr_pkg::mode_idle);
  assign self_prog_control_reg = {s.int_en, s.conc_busy, s.cmd, self_prog_enable};
  assign status_reg = {eeprom_write_pending, cpu_halt, 1'b0, s.mode};

  assign acc             = avs_read | avs_write;
  assign avs_waitrequest = acc & ~s.ack;
  assign do_write        = avs_write & s.ack & avs_byteenable[0];
  assign ctrl_sel        = (avs_address == `FLSR_CTRL_ADDR);
  assign stat_sel        = (avs_address == `FLSR_STAT_ADDR);

  // special reads only inside the three-cycle load window
  assign special_load = ((s.mode == flsr_pkg::mode_info) ||
                         (s.mode == flsr_pkg::mode_sig)) &&
                        (win_count > `FLSR_LOAD_OPEN);
  assign store_ok = store_req && (win_count != 3'h0) &&
                    ((s.mode == flsr_pkg::mode_info) ||
                     (s.mode == flsr_pkg::mode_store));
  assign conc_target = (z_ptr[15:1] < `FLSR_BLOCK_START);

  // stored command bits, bit 0 of cmd is the erase bit
  assign cmd_erase  = s.cmd[`FLSR_BIT_ERASE-1];
  assign cmd_write  = s.cmd[`FLSR_BIT_WRITE-1];
  assign cmd_rww_en = s.cmd[`FLSR_BIT_RWW_EN-1];

  // ordinary flash read, byte picked by the low pointer bit
  assign flash_rd_req  = load_req & ~special_load;
  assign flash_rd_addr = z_ptr[15:1];
  assign flash_byte    = z_ptr[0] ? flash_rd_data[15:8] : flash_rd_data[7:0];

  always_comb begin
    next_s       = s;
    win_load     = 1'b0;
    prog_load    = 1'b0;
    next_s.ack        = acc & ~s.ack;
    next_s.load_valid = 1'b0;
    next_s.op_start   = 1'b0;

    // register read data captured in the wait cycle
    if (avs_read && !s.ack) begin
      if (ctrl_sel) begin
        next_s.rdata = {24'h000000, self_prog_control_reg};
      end else if (stat_sel) begin
        next_s.rdata = {24'h000000, status_reg};
      end else begin
        next_s.rdata = 32'h00000000;
      end
    end

    // window expiry without the expected instruction, or end of the program timer
    case (s.mode)
      flsr_pkg::mode_sig: begin
        if (win_count == `FLSR_SIG_LAST && !load_req) begin
          next_s.mode = flsr_pkg::mode_idle;
          next_s.cmd  = 5'h00;
        end
      end
      flsr_pkg::mode_info: begin
        if (win_last && !store_req) begin
          next_s.mode = flsr_pkg::mode_idle;
          next_s.cmd  = 5'h00;
        end
      end
      flsr_pkg::mode_store: begin
        if (win_last && !store_req) begin
          next_s.mode = flsr_pkg::mode_idle;
          next_s.cmd  = 5'h00;
        end
      end
      flsr_pkg::mode_prog: begin
        if (prog_last) begin
          next_s.mode          = flsr_pkg::mode_idle;
          next_s.cmd           = 5'h00;
          next_s.prog_blocking = 1'b0;
        end
      end
      flsr_pkg::mode_idle: begin
        next_s.cmd = 5'h00;
      end
      default: begin
        next_s.mode = flsr_pkg::mode_idle;
        next_s.cmd  = 5'h00;
      end
    endcase

    // cpu load
    if (load_req) begin
      next_s.load_valid = 1'b1;
      if (special_load) begin
        next_s.load_data = info_byte;
        next_s.mode      = flsr_pkg::mode_idle;
        next_s.cmd       = 5'h00;
      end else begin
        next_s.load_data = flash_byte;
      end
    end

    // cpu store inside the four-cycle window
    if (store_ok) begin
      next_s.op_start = 1'b1;
      next_s.op_addr  = z_ptr;
      next_s.op_data  = store_data;
      next_s.mode     = flsr_pkg::mode_idle;
      next_s.cmd      = 5'h00;
      if (s.mode == flsr_pkg::mode_info) begin
        next_s.op_code = flsr_pkg::op_lock;
        next_s.mode    = flsr_pkg::mode_prog;
        next_s.cmd     = s.cmd;
        prog_load      = 1'b1;
      end else if (cmd_erase || cmd_write) begin
        next_s.op_code = cmd_erase ? flsr_pkg::op_erase : flsr_pkg::op_write;
        next_s.mode    = flsr_pkg::mode_prog;
        next_s.cmd     = s.cmd;
        prog_load      = 1'b1;
        if (conc_target) begin
          next_s.conc_busy = 1'b1;
        end else begin
          next_s.prog_blocking = 1'b1;
        end
      end else if (cmd_rww_en) begin
        next_s.op_code   = flsr_pkg::op_rww_en;
        next_s.conc_busy = 1'b0;
      end else begin
        next_s.op_code   = flsr_pkg::op_load;
        next_s.conc_busy = 1'b0;
      end
    end

    // control register write; command bits held off while eeprom writes or flash programs, int_en always taken
    if (do_write && ctrl_sel) begin
      next_s.int_en = avs_writedata[`FLSR_BIT_INT_EN];
      if (!eeprom_write_pending && !prog_active && !store_ok) begin
        if (avs_writedata[`FLSR_BIT_ENABLE]) begin
          win_load   = 1'b1;
          next_s.cmd = avs_writedata[`FLSR_BIT_SIG:`FLSR_BIT_ERASE];
          if (avs_writedata[`FLSR_BIT_SIG]) begin
            next_s.mode = flsr_pkg::mode_sig;
          end else if (avs_writedata[`FLSR_BIT_LOCK]) begin
            next_s.mode = flsr_pkg::mode_info;
          end else begin
            next_s.mode = flsr_pkg::mode_store;
          end
        end else begin
          next_s.mode = flsr_pkg::mode_idle;
          next_s.cmd  = 5'h00;
        end
      end
    end

    // system reset clears commands but lets a running program op finish
    if (!rst_n) begin
      next_s.cmd        = 5'h00;
      next_s.int_en     = 1'b0;
      next_s.ack        = 1'b0;
      next_s.rdata      = 32'h00000000;
      next_s.load_data  = 8'h00;
      next_s.load_valid = 1'b0;
      next_s.op_start   = 1'b0;
      next_s.op_code    = flsr_pkg::op_none;
      next_s.op_addr    = 16'h0000;
      next_s.op_data    = 16'h0000;
      if (!prog_active) begin
        next_s.mode          = flsr_pkg::mode_idle;
        next_s.prog_blocking = 1'b0;
      end else begin
        // the timer still ends the running op
        next_s.mode          = prog_last ? flsr_pkg::mode_idle : flsr_pkg::mode_prog;
        next_s.prog_blocking = prog_last ? 1'b0 : s.prog_blocking;
      end
      prog_load = 1'b0;
    end

    // power-on clears all state and the program timer, but not the window counter
    if (!por_n) begin
      next_s.mode          = flsr_pkg::mode_idle;
      next_s.cmd           = 5'h00;
      next_s.int_en        = 1'b0;
      next_s.conc_busy     = 1'b0;
      next_s.prog_blocking = 1'b0;
      next_s.ack           = 1'b0;
      next_s.rdata         = 32'h00000000;
      next_s.load_data     = 8'h00;
      next_s.load_valid    = 1'b0;
      next_s.op_start      = 1'b0;
      next_s.op_code       = flsr_pkg::op_none;
      next_s.op_addr       = 16'h0000;
      next_s.op_data       = 16'h0000;
      prog_load            = 1'b0;
      win_load             = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign avs_readdata            = s.rdata;
  assign load_data               = s.load_data;
  assign load_valid              = s.load_valid;
  assign flash_op_start          = s.op_start;
  assign flash_op_code           = s.op_code;
  assign flash_op_addr           = s.op_addr;
  assign flash_op_data           = s.op_data;
  assign cpu_halt                = prog_active & s.prog_blocking;
  assign concurrent_section_busy = s.conc_busy;

  logic unused_prog;
  assign unused_prog = ^prog_count;

endmodule : flsr_reader
`default_nettype wire

// ---- testbench/flsr_reader_asserts.sv ----
// checker for the fuse, lock and signature reader ports
// assumes it is bound into flsr_reader with the same program count
`default_nettype none
module flsr_reader_chk #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               por_n,
  input wire logic               load_req,
  input wire logic               store_req,
  input wire logic [15:0]        z_ptr,
  input wire logic [15:0]        flash_rd_data,
  input wire logic [7:0]         load_data,
  input wire logic               load_valid,
  input wire logic               flash_rd_req,
  input wire logic [14:0]        flash_rd_addr,
  input wire logic               flash_op_start,
  input wire flsr_pkg::flsr_op_t flash_op_code,
  input wire logic               cpu_halt,
  input wire logic               concurrent_section_busy
);
  int halt_len;

  // length of the current halt
  always_ff @(posedge clk) begin
    if (!por_n) begin
      halt_len <= 0;
    end else if (cpu_halt) begin
      halt_len <= halt_len + 1;
    end else begin
      halt_len <= 0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  load_answer_a: assert property (load_valid == $past(load_req))
    else $error("load result not one cycle after load");
  no_flash_a: assert property (!load_req |-> !flash_rd_req)
    else $error("flash read without load");
  word_addr_a: assert property (flash_rd_req |-> flash_rd_addr == z_ptr[15:1])
    else $error("flash word address wrong");
  flash_byte_a: assert property (flash_rd_req |=> load_data == ($past(z_ptr[0]) ?
    $past(flash_rd_data[15:8]) : $past(flash_rd_data[7:0])))
    else $error("ordinary load byte wrong");
  op_cause_a: assert property (flash_op_start |-> $past(store_req))
    else $error("flash op without store");
  halt_start_a: assert property ($rose(cpu_halt) |-> flash_op_start &&
    flash_op_code inside {flsr_pkg::op_erase, flsr_pkg::op_write})
    else $error("halt without erase or write");
  halt_hold_a: assert property ($rose(cpu_halt) |=> cpu_halt[*8])
    else $error("halt too short");
  prog_time_a: assert property ($fell(cpu_halt) |->
    halt_len >= PROG_CYCLES - 2 && halt_len <= PROG_CYCLES + 2)
    else $error("program time off");
  busy_set_a: assert property (flash_op_start && !cpu_halt &&
    flash_op_code inside {flsr_pkg::op_erase, flsr_pkg::op_write}
    |-> ##[0:1] concurrent_section_busy)
    else $error("busy not set");
  busy_clear_a: assert property (flash_op_start &&
    flash_op_code == flsr_pkg::op_rww_en |-> ##[0:1] !concurrent_section_busy)
    else $error("busy not cleared");
  busy_cause_a: assert property ($rose(concurrent_section_busy) |->
    flash_op_start || $past(flash_op_start))
    else $error("busy set without op");

  cover property (load_req && !flash_rd_req);
  cover property ($rose(cpu_halt));
  cover property ($rose(concurrent_section_busy));
endmodule : flsr_reader_chk

bind flsr_reader flsr_reader_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
  .clk(clk), .rst_n(rst_n), .por_n(por_n), .load_req(load_req), .store_req(store_req),
  .z_ptr(z_ptr), .flash_rd_data(flash_rd_data), .load_data(load_data),
  .load_valid(load_valid), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
  .flash_op_start(flash_op_start), .flash_op_code(flash_op_code), .cpu_halt(cpu_halt),
  .concurrent_section_busy(concurrent_section_busy)
);
`default_nettype wire

// ---- testbench/flsr_reader_test.sv ----
// self-checking bench for flsr_reader: avalon tasks, cpu load and store pulses
// assumes flsr_cfg.svh, flsr_pkg and the design files are compiled first
`include "flsr_cfg.svh"
`default_nettype none
module flsr_reader_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         PC   = 20;
  localparam logic [7:0] CTRL = `FLSR_CTRL_ADDR;
  // signature ids built into the design, arbitrary values
  localparam logic [7:0] ID1  = 8'h5a;
  localparam logic [7:0] ID2  = 8'ha5;
  localparam logic [7:0] ID3  = 8'h3c;
  logic        clk, rst_n, por_n, avs_read, avs_write, avs_waitrequest, load_req, store_req;
  logic        eeprom_write_pending, load_valid, flash_rd_req, flash_op_start, cpu_halt, busy;
  logic [3:0]  be;
  logic [5:0]  lk;
  logic [7:0]  avs_address, load_data, rd, fl, fh, fe, oc, tof, tg;
  logic [7:0]  fx [4];
  logic [7:0]  sx [5];
  logic [14:0] flash_rd_addr;
  logic [15:0] z_ptr, sd, frd, op_addr, op_data;
  logic [31:0] avs_writedata, avs_readdata;
  flsr_pkg::flsr_op_t op_code;
  int          err_count, total_checks;
  time         t0;

  flsr_reader #(.PROG_CYCLES(PC)) dut_u (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .load_req(load_req),
    .store_req(store_req), .z_ptr(z_ptr), .store_data(sd), .load_data(load_data),
    .load_valid(load_valid), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(frd), .eeprom_write_pending(eeprom_write_pending),
    .fuse_low_prog(fl), .fuse_high_prog(fh), .fuse_ext_prog(fe), .lock_prog(lk),
    .osc_cal(oc), .temp_sensor_offset(tof), .temp_sensor_gain(tg),
    .flash_op_start(flash_op_start), .flash_op_code(op_code), .flash_op_addr(op_addr),
    .flash_op_data(op_data), .cpu_halt(cpu_halt), .concurrent_section_busy(busy)
  );

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string m);
    bus(1'b0, a, 8'h00, rd);
    chk(rd, exp, m);
  endtask : rdchk

  // cpu load after dly cycles; spec says a fuse, lock or signature byte is due
  task automatic ld(input logic [15:0] p, input int dly, input logic spec,
                    input logic [7:0] exp);
    repeat (dly) @(posedge clk);
    z_ptr    <= p;
    load_req <= 1'b1;
    @(negedge clk);
    chk(flash_rd_req, !spec, "flash strobe");
    chk(flash_rd_addr, p[15:1], "flash word");
    @(posedge clk);
    load_req <= 1'b0;
    @(negedge clk);
    chk({load_valid, load_data}, {1'b1, exp}, "load byte");
    @(posedge clk);
  endtask : ld

  // command write, then a store in the first cycle of the window
  task automatic st(input logic [15:0] p, input logic [7:0] cmd);
    bus(1'b1, CTRL, cmd, rd);
    z_ptr     <= p;
    sd        <= {8'hc0, cmd};
    store_req <= 1'b1;
    @(posedge clk);
    store_req <= 1'b0;
    @(negedge clk);
    t0 = $time;
    chk(flash_op_start, 1'b1, "op start");
    chk({op_addr, op_data}, {p, 8'hc0, cmd}, "op address and data");
  endtask : st

  task automatic wait_done(input logic exp_busy);
    bus(1'b0, CTRL, 8'h00, rd);
    chk({rd[6], rd[0]}, {exp_busy, 1'b1}, "busy while programming");
    while (rd[0] !== 1'b0) bus(1'b0, CTRL, 8'h00, rd);
    chk(($time - t0) / 10 inside {[PC - 2 : PC + 6]}, 1'b1, "program time");
    chk(rd[6], exp_busy, "busy after program");
  endtask : wait_done

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial begin
    {clk, rst_n, por_n, avs_read, avs_write, load_req, store_req, eeprom_write_pending} = '0;
    {avs_address, avs_writedata, z_ptr, sd} = '0;
    {be, frd, fl, fh, fe, lk, oc, tof, tg} =
      {4'h1, 16'h1e2d, 8'h81, 8'h42, 8'h07, 6'h15, 8'h9c, 8'h11, 8'h6b};
    fx = '{~fl, {2'b11, ~lk}, ~fe, ~fh};
    sx = '{ID1, oc, ID2, tg, ID3};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rdchk(CTRL, 8'h00, "ctrl at reset");
    rdchk(`FLSR_STAT_ADDR, 8'h01, "status at reset");
    rdchk(8'h40, 8'h00, "unmapped");
    ld(16'h0005, 0, 1'b0, 8'h1e);
    ld(16'h0004, 0, 1'b0, 8'h2d);
    $display("test reset and plain loads done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, CTRL, 8'h09, rd);
      ld(16'(i), i % 3, 1'b1, fx[i]);
      rdchk(CTRL, 8'h00, "lock mode left");
    end
    $display("test fuse and lock reads done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, CTRL, 8'h21, rd);
      ld(16'(i), (i + 1) % 3, 1'b1, sx[i]);
      rdchk(CTRL, 8'h00, "signature mode left");
    end
    $display("test signature reads done");
    bus(1'b1, CTRL, 8'h09, rd);
    ld(16'h0001, 3, 1'b0, 8'h1e);
    bus(1'b1, CTRL, 8'h21, rd);
    ld(16'h0000, 3, 1'b0, 8'h2d);
    rdchk(CTRL, 8'h00, "window expired");
    $display("test window expiry done");
    eeprom_write_pending <= 1'b1;
    bus(1'b1, CTRL, 8'h89, rd);
    rdchk(CTRL, 8'h80, "command refused");
    rdchk(`FLSR_STAT_ADDR, 8'h81, "status pending");
    eeprom_write_pending <= 1'b0;
    bus(1'b1, CTRL, 8'h00, rd);
    $display("test eeprom block done");
    st(16'h0100, 8'h03);
    chk(op_code, flsr_pkg::op_erase, "erase code");
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    wait_done(1'b1);
    st(16'h0000, 8'h11);
    chk(op_code, flsr_pkg::op_rww_en, "read enable code");
    rdchk(CTRL, 8'h00, "busy cleared");
    st(16'h0100, 8'h03);
    wait_done(1'b1);
    st(16'h0002, 8'h01);
    chk(op_code, flsr_pkg::op_load, "page load code");
    rdchk(CTRL, 8'h00, "page load clears busy");
    st(16'h7000, 8'h05);
    chk({cpu_halt, busy, op_code}, {2'b10, flsr_pkg::op_write}, "blocking write");
    wait_done(1'b0);
    chk(cpu_halt, 1'b0, "halt released");
    st(16'h0001, 8'h09);
    chk(op_code, flsr_pkg::op_lock, "lock write code");
    wait_done(1'b0);
    $display("test programming done");
    wrap_up();
  end
endmodule : flsr_reader_test
`default_nettype wire
